// >>> src/hpsc_slot_ctrl.sv
// Hot-plug slot control register bank with slot status flags and interrupt.
// Slot events arrive as one-cycle pulses synchronous to aclk; actions of a control
// write are acknowledged by the slot side through action_done.
// How it works
// RULE1: Button enable lets a button press raise interrupt or wake; else nothing.
// RULE2: Power fault enable gates the power fault event.
// RULE3: Latch sensor change enable gates latch change events.
// RULE4: Presence change enable gates presence changes; never capability-masked.
// RULE5: Command done enable gates completion interrupt; no wake from it.
// RULE6: Master enable gates all hot-plug interrupts, each also needing its own enable.
// RULE7: Fields without their capability are read-only zero, except presence and link enables.
// RULE8: Attention indicator resets off, writes set it and send a message.
// RULE9: Attention indicator reads zero without its present capability.
// RULE10: Power indicator resets on, writes set it and send a message.
// RULE11: Power indicator reads zero without its present capability.
// RULE12: On the upstream port power indicator writes have no effect.
// RULE13: Slot power control resets on; read returns applied power state.
// RULE14: Interlock control reads zero; writing one toggles interlock, zero does nothing.
// RULE15: Link active change enable gates link active change events.
// RULE16: Command done set only after all actions of one write finish; sticky.
// RULE17: Event flags set by events and cleared by writing one.
// RULE18: Interrupt while any enabled flag set and master enable set.
// RULE19: Control bits 15 to 13 read zero.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module hpsc_slot_ctrl
	import hpsc_pkg::*;
#(
	parameter bit UPSTREAM = 1'b0
)
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [HPSC_AW-1:0]  s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [HPSC_AW-1:0]  s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                button_press,
	input  wire logic                power_fault,
	input  wire logic                latch_change,
	input  wire logic                presence_change,
	input  wire logic                link_active_change,
	input  wire logic                latch_open,
	input  wire logic                card_present,
	input  wire logic                action_done,
	output logic                     action_start,
	output logic [1:0]               attention_indicator,
	output logic [1:0]               power_indicator,
	output logic                     slot_power_off,
	output logic                     interlock_engaged,
	output logic                     attn_msg_send,
	output logic                     pwr_msg_send,
	output logic                     hotplug_irq,
	output logic                     hotplug_wake,
	output logic                     irq
);

	// Register state
	logic [31:0]  caps_q;
	logic [15:0]  ctrl_q;
	logic [8:0]   flags_q;
	logic [4:0]   intst_q;
	logic [4:0]   intmsk_q;
	logic         ilk_q;
	logic         aw_held_q;
	logic         w_held_q;
	logic [HPSC_AW-1:0] awaddr_q;
	logic [31:0]  wdata_q;
	logic [3:0]   wstrb_q;
	hpsc_cmd_type cmd_q;
	logic         ctrl_pend_q;
	logic [15:0]  prev_ctrl_q;

	// Write channel acceptance: address and data taken in any order
	// A channel that arrives first is parked in a holding register until its partner
	// shows up, so a master that staggers the two still gets one response.
	wire          aw_take = s_axi_awvalid && s_axi_awready;
	wire          w_take  = s_axi_wvalid && s_axi_wready;
	wire          aw_have = aw_held_q || aw_take;
	wire          w_have  = w_held_q || w_take;
	wire          wr_fire = aw_have && w_have && !s_axi_bvalid;
	wire [HPSC_AW-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0]   wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0]    wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	wire [31:0]   wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [31:0]   wbits = wr_data & wmask;

	// Write decode
	wire          wr_caps   = wr_fire && (wr_addr == HPSC_OFF_CAPS);
	wire          wr_ctrl   = wr_fire && (wr_addr == HPSC_OFF_CTRL) && (wr_strb[1:0] != 2'h0);
	wire          wr_stat   = wr_fire && (wr_addr == HPSC_OFF_STAT);
	wire          wr_intst  = wr_fire && (wr_addr == HPSC_OFF_INTST);
	wire          wr_intmsk = wr_fire && (wr_addr == HPSC_OFF_INTMSK);
	wire          wr_ok     = (wr_addr == HPSC_OFF_CAPS) || (wr_addr == HPSC_OFF_CTRL) ||
	                          (wr_addr == HPSC_OFF_STAT) || (wr_addr == HPSC_OFF_INTST) ||
	                          (wr_addr == HPSC_OFF_INTMSK) || (wr_addr == HPSC_OFF_ENV);

	// Capability-derived writable mask of the control register
	// Capability bits are live: clearing one hides the field at once while the stored
	// value is kept, so setting the capability again brings the old setting back.
	wire          cap_btn   = caps_q[K_BTN];
	wire          cap_pwr   = caps_q[K_PWR];
	wire          cap_latch = caps_q[K_LATCH];
	wire          cap_ai    = caps_q[K_AI];
	wire          cap_pi    = caps_q[K_PI];
	wire          cap_hpc   = caps_q[K_HPC];
	wire          cap_ilk   = caps_q[K_ILK];
	wire [15:0]   ctrl_cap_mask = {3'h0,                            // RULE19
	                               1'b1,                            // RULE15
	                               cap_ilk, cap_pwr,
	                               {2{cap_pi}}, {2{cap_ai}},        // RULE9 RULE11
	                               cap_hpc, cap_hpc, 1'b1,          // RULE4
	                               cap_latch, cap_pwr, cap_btn};    // RULE7
	// Bits of slot control a write can change; interlock is a strobe only
	wire [15:0]   ctrl_wmask = ctrl_cap_mask & ~(16'h1 << C_ILK) &
	                           {{8{wr_strb[1]}}, {8{wr_strb[0]}}} &
	                           (UPSTREAM ? ~(16'h3 << C_PI_LO) : 16'hFFFF); // RULE12
	wire [15:0]   ctrl_vis  = ctrl_q & ctrl_cap_mask & ~(16'h1 << C_ILK);  // RULE14 RULE7
	wire [15:0]   ctrl_next = (ctrl_q & ~ctrl_wmask) | (wbits[15:0] & ctrl_wmask);
	wire          ilk_toggle = wr_ctrl && wr_strb[1] && wbits[C_ILK] && cap_ilk; // RULE14

	// Event capture; presence and link changes ignore capabilities
	// Events are single-cycle pulses; a held level would set a flag every cycle,
	// which is harmless because the flags are sticky anyway.
	wire [8:0]    ev_set;
	assign ev_set[S_BTN]   = button_press && cap_btn;
	assign ev_set[S_PFLT]  = power_fault && cap_pwr;
	assign ev_set[S_LATCH] = latch_change && cap_latch;
	assign ev_set[S_PRES]  = presence_change;
	assign ev_set[S_CMD]   = (cmd_q == CS_DONE);
	assign ev_set[S_LSTAT] = 1'b0;
	assign ev_set[S_PSTAT] = 1'b0;
	assign ev_set[S_ILKST] = 1'b0;
	assign ev_set[S_LINK]  = link_active_change;
	wire [8:0]    flag_clr = wr_stat ? (wbits[8:0] & S_RW1C_MASK) : 9'h0;
	wire [8:0]    flags_d  = (flags_q & ~flag_clr) | ev_set;   // RULE17

	// Enabled event terms; wake excludes command completion
	// Wake needs no master enable, so a sleeping port can still be woken by the slot.
	// Command completion only interrupts; it never wakes.
	wire          en_btn   = flags_q[S_BTN]   && ctrl_vis[C_BTN];   // RULE1
	wire          en_pflt  = flags_q[S_PFLT]  && ctrl_vis[C_PFLT];  // RULE2
	wire          en_latch = flags_q[S_LATCH] && ctrl_vis[C_LATCH]; // RULE3
	wire          en_pres  = flags_q[S_PRES]  && ctrl_vis[C_PRES];  // RULE4
	wire          en_cmd   = flags_q[S_CMD]   && ctrl_vis[C_CMD];   // RULE5
	wire          en_link  = flags_q[S_LINK]  && ctrl_vis[C_LINK];  // RULE15
	wire          wake_any = en_btn || en_pflt || en_latch || en_pres || en_link;
	wire          irq_d    = ctrl_vis[C_MHP] && (wake_any || en_cmd); // RULE6 RULE18

	// Local interrupt events: hot-plug irq edge, command done, any slot event
	// The hot-plug term records the rising edge rather than the level, so software
	// sees a new event even after the level has fallen again.
	wire [4:0]    int_ev = {ev_set[S_LINK], ev_set[S_PRES], |ev_set[S_LATCH:S_BTN],
	                        ev_set[S_CMD], irq_d && !hotplug_irq};
	wire [4:0]    intst_d = (intst_q & ~(wr_intst ? wbits[4:0] : 5'h0)) | int_ev;

	// Read side
	// Decode uses the live read address; it is only sampled on the handshake edge,
	// where the master is still holding it.
	wire          rd_take = s_axi_arvalid && s_axi_arready;
	wire [31:0]   stat_word = {23'h0, flags_q[S_LINK], ilk_q, card_present, latch_open,
	                           flags_q[S_CMD:S_BTN]};
	wire [31:0]   env_word = {31'h0, UPSTREAM};
	wire [31:0]   rd_word = (s_axi_araddr == HPSC_OFF_CAPS)   ? caps_q :
	                        (s_axi_araddr == HPSC_OFF_CTRL)   ? {16'h0, ctrl_vis} :
	                        (s_axi_araddr == HPSC_OFF_STAT)   ? stat_word :
	                        (s_axi_araddr == HPSC_OFF_INTST)  ? {27'h0, intst_q} :
	                        (s_axi_araddr == HPSC_OFF_INTMSK) ? {27'h0, intmsk_q} :
	                        (s_axi_araddr == HPSC_OFF_ENV)    ? env_word : 32'h0;
	wire          rd_ok   = (s_axi_araddr == HPSC_OFF_CAPS) || (s_axi_araddr == HPSC_OFF_CTRL) ||
	                        (s_axi_araddr == HPSC_OFF_STAT) || (s_axi_araddr == HPSC_OFF_INTST) ||
	                        (s_axi_araddr == HPSC_OFF_INTMSK) || (s_axi_araddr == HPSC_OFF_ENV);

	// Indicator write detection for message strobes
	// Any write reaching the indicator byte sends a message, even with an unchanged
	// value, so the slot can resynchronise its lamps from software.
	wire          ai_written = wr_ctrl && wr_strb[0] && cap_ai;                 // RULE8
	wire          pi_written = wr_ctrl && wr_strb[1] && cap_pi && !UPSTREAM;    // RULE10 RULE12

	// AXI write handshake and holding registers
	// Ready is withheld while a response waits, which throttles a master that
	// issues back-to-back writes without blocking it forever.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_held_q     <= aw_have && !wr_fire;
			w_held_q      <= w_have && !wr_fire;
			// Each ready only while its own channel holds nothing, so each channel is taken once
			s_axi_awready <= !aw_have && !s_axi_bvalid && !(wr_fire);
			s_axi_wready  <= !w_have && !s_axi_bvalid && !(wr_fire);
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI read: one-cycle ready pulse, data registered
	// Ready drops after each take and stays low until rready drains the answer, so
	// only one read is ever outstanding.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Capabilities and slot control storage
	// Capabilities stay writable so software can describe the slot hardware;
	// a fixed product would load them once at start-up instead.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			caps_q   <= CAPS_RST;
			ctrl_q   <= CTRL_RST;      // RULE8 RULE10 RULE13
			ilk_q    <= 1'b0;
			intmsk_q <= 5'h0;
		end
		else
		begin
			if (wr_caps)
				caps_q <= (caps_q & ~wmask) | wbits;
			if (wr_ctrl)
				ctrl_q <= ctrl_next;
			if (ilk_toggle)
				ilk_q <= !ilk_q;       // RULE14
			if (wr_intmsk)
				intmsk_q <= wbits[4:0];
		end
	end

	// Flags; a set in the clearing cycle survives
	// Losing an event is worse than reporting one that software has just
	// acknowledged, so the set term is ORed in after the clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flags_q <= 9'h0;
			intst_q <= 5'h0;
		end
		else
		begin
			flags_q <= flags_d;        // RULE17
			intst_q <= intst_d;
		end
	end

	// Command completion: one control write is one command, done after the slot side acks
	// A write landing while a command runs is queued by the pending bit and starts
	// as soon as the machine is idle again; several such writes merge into one.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_q        <= CS_IDLE;
			ctrl_pend_q  <= 1'b0;
			action_start <= 1'b0;
			prev_ctrl_q  <= CTRL_RST;
		end
		else
		begin
			action_start <= 1'b0;
			if (wr_ctrl)
				ctrl_pend_q <= 1'b1;
			case (cmd_q)
				CS_IDLE:
				begin
					if (ctrl_pend_q && !wr_ctrl)
					begin
						ctrl_pend_q  <= 1'b0;
						action_start <= 1'b1;
						prev_ctrl_q  <= ctrl_q;
						cmd_q        <= CS_BUSY;
					end
				end
				CS_BUSY:
				begin
					if (action_done && !action_start)
						cmd_q <= CS_DONE;  // RULE16
				end
				CS_DONE:
					cmd_q <= CS_IDLE;
				default:
					cmd_q <= CS_IDLE;
			endcase
		end
	end

	// Slot-facing outputs, all registered
	// Outputs follow the visible field, so a slot without an indicator sees zero,
	// never a stale setting from before its capability was cleared.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			attention_indicator <= AI_RST;
			power_indicator     <= PI_RST;
			slot_power_off      <= 1'b0;
			interlock_engaged   <= 1'b0;
			attn_msg_send       <= 1'b0;
			pwr_msg_send        <= 1'b0;
			hotplug_irq         <= 1'b0;
			hotplug_wake        <= 1'b0;
			irq                 <= 1'b0;
		end
		else
		begin
			attention_indicator <= ctrl_vis[C_AI_LO +: 2];
			power_indicator     <= ctrl_vis[C_PI_LO +: 2];
			slot_power_off      <= ctrl_vis[C_PWR];        // RULE13
			interlock_engaged   <= ilk_q;
			attn_msg_send       <= ai_written;             // RULE8
			pwr_msg_send        <= pi_written;             // RULE10
			hotplug_irq         <= irq_d;                  // RULE18
			hotplug_wake        <= wake_any;               // RULE5
			irq                 <= |(intst_d & intmsk_q);
		end
	end

	// Protection bits are accepted but not used
	wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, prev_ctrl_q, wbits[31:16]};

endmodule
`default_nettype wire

// >>> src/hpsc_pkg.sv
// Package for the hot-plug slot control block: register map, field layout, encodings.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package hpsc_pkg;
	// Byte addresses of the registers
	localparam logic [11:0] HPSC_OFF_CAPS   = 12'h054;
	localparam logic [11:0] HPSC_OFF_CTRL   = 12'h058;
	localparam logic [11:0] HPSC_OFF_STAT   = 12'h05C;
	localparam logic [11:0] HPSC_OFF_INTST  = 12'h060;
	localparam logic [11:0] HPSC_OFF_INTMSK = 12'h064;
	localparam logic [11:0] HPSC_OFF_ENV    = 12'h068;
	localparam int HPSC_AW = 12;
	// Slot control field positions
	localparam int C_BTN   = 0;
	localparam int C_PFLT  = 1;
	localparam int C_LATCH = 2;
	localparam int C_PRES  = 3;
	localparam int C_CMD   = 4;
	localparam int C_MHP   = 5;
	localparam int C_AI_LO = 6;
	localparam int C_PI_LO = 8;
	localparam int C_PWR   = 10;
	localparam int C_ILK   = 11;
	localparam int C_LINK  = 12;
	// Slot capabilities field positions
	localparam int K_BTN   = 0;
	localparam int K_PWR   = 1;
	localparam int K_LATCH = 2;
	localparam int K_AI    = 3;
	localparam int K_PI    = 4;
	localparam int K_HPC   = 6;
	localparam int K_ILK   = 17;
	// Slot status flag positions
	localparam int S_BTN   = 0;
	localparam int S_PFLT  = 1;
	localparam int S_LATCH = 2;
	localparam int S_PRES  = 3;
	localparam int S_CMD   = 4;
	localparam int S_LSTAT = 5;
	localparam int S_PSTAT = 6;
	localparam int S_ILKST = 7;
	localparam int S_LINK  = 8;
	localparam logic [8:0] S_RW1C_MASK = 9'h11F;
	// Reset values
	localparam logic [1:0]  AI_RST   = 2'h3;
	localparam logic [1:0]  PI_RST   = 2'h1;
	localparam logic [15:0] CTRL_RST = 16'h01C0;
	localparam logic [31:0] CAPS_RST = 32'h0000_0000;
	// Indicator encodings
	localparam logic [1:0] IND_ON    = 2'h1;
	localparam logic [1:0] IND_BLINK = 2'h2;
	localparam logic [1:0] IND_OFF   = 2'h3;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Command completion state machine
	typedef enum logic [2:0]
	{
		CS_IDLE = 3'b001,
		CS_BUSY = 3'b010,
		CS_DONE = 3'b100
	} hpsc_cmd_type;
endpackage

// >>> testbench/hpsc_slot_chk.sv
// Checker for the slot control block, watching its top-level ports only.
// Assumes the master holds bready and rready high while it awaits an answer.
`timescale 1ns/1ns
`default_nettype none
module hpsc_slot_chk
	import hpsc_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_bvalid,
	input wire logic       action_start,
	input wire logic [1:0] attention_indicator,
	input wire logic [1:0] power_indicator,
	input wire logic       slot_power_off,
	input wire logic       interlock_engaged,
	input wire logic       attn_msg_send,
	input wire logic       pwr_msg_send,
	input wire logic       hotplug_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_attn_reset: assert property (
		disable iff (1'h0) !aresetn ##1 !aresetn |-> attention_indicator == AI_RST)
		else $error("attention indicator not off in reset");
	a_power_reset: assert property (
		disable iff (1'h0) !aresetn ##1 !aresetn |-> power_indicator == PI_RST && !slot_power_off)
		else $error("power indicator or slot power wrong in reset");
	a_attn_msg: assert property (attn_msg_send |-> s_axi_bvalid)
		else $error("attention message without a write");
	a_pwr_msg: assert property (pwr_msg_send |-> s_axi_bvalid ##1 !pwr_msg_send)
		else $error("power message not a pulse after a write");
	a_attn_change: assert property (
		$past(aresetn, 2) && $changed(attention_indicator) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("attention indicator moved without a write");
	a_power_change: assert property (
		$past(aresetn) && $changed(slot_power_off) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("slot power moved without a write");
	a_ilk_toggle: assert property (
		$past(aresetn) && $changed(interlock_engaged) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("interlock moved without a write");
	a_start_write: assert property (action_start |-> $past(s_axi_bvalid) ##1 !action_start)
		else $error("command start not tied to one write");

	// Main scenarios reached
	c_msg: cover property (attn_msg_send);
	c_start: cover property (action_start);
	c_irq: cover property ($rose(hotplug_irq));
endmodule
bind hpsc_slot_ctrl hpsc_slot_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .action_start,
	.attention_indicator, .power_indicator, .slot_power_off, .interlock_engaged,
	.attn_msg_send, .pwr_msg_send, .hotplug_irq);
`default_nettype wire

// >>> testbench/hpsc_slot_model.sv
// Slot-side model: answers each command start with a done pulse after DELAY cycles.
// Assumes action_start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ns
`default_nettype none
module hpsc_slot_model #(
	parameter int DELAY = 20
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic action_start,
	output logic      action_done
);
	int cnt_q;
	// Slow answer so software can see a command still running
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 0;
		else if (action_start)
			cnt_q <= DELAY;
		else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
	end
	assign action_done = (cnt_q == 1);
endmodule
`default_nettype wire

// >>> testbench/tb_hotplug_slot_control.sv
// Testbench for the slot control block: register, command, event and interrupt tests.
// Assumes the slot model answers commands; expected values come from the field layout.
`timescale 1ns/1ns
`default_nettype none
module tb_hotplug_slot_control import hpsc_pkg::*;;
	localparam int DLY = 20;
	logic        aclk = 1'h0, aresetn = 1'h0, done, start, poff, ilk, amsg, pmsg, hirq, wake, irq;
	logic        up_pmsg;
	logic [1:0]  up_pwr;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, rd_q, d;
	logic [1:0]  bresp, rresp, att, pwr;
	logic [4:0]  ev = 5'h0;
	int          err_total = 0, checks = 0, cyc = 0, n_attn = 0, n_pwr = 0, n_up = 0;
	int          en_b[5] = '{0, 1, 2, 3, 12};
	int          st_b[5] = '{0, 1, 2, 3, 8};

	hpsc_slot_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.button_press(ev[0]), .power_fault(ev[1]), .latch_change(ev[2]),
		.presence_change(ev[3]), .link_active_change(ev[4]), .latch_open(1'h0),
		.card_present(1'h1), .action_done(done), .action_start(start),
		.attention_indicator(att), .power_indicator(pwr), .slot_power_off(poff),
		.interlock_engaged(ilk), .attn_msg_send(amsg), .pwr_msg_send(pmsg),
		.hotplug_irq(hirq), .hotplug_wake(wake), .irq(irq));
	// Upstream copy runs in lockstep on the same bus; only its power indicator and power message are watched
	hpsc_slot_ctrl #(.UPSTREAM(1'b1)) u_up (.aclk, .aresetn, .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready(rready), .button_press(ev[0]), .power_fault(ev[1]),
		.latch_change(ev[2]), .presence_change(ev[3]), .link_active_change(ev[4]),
		.latch_open(1'h0), .card_present(1'h1), .action_done(done), .action_start(),
		.attention_indicator(), .power_indicator(up_pwr), .slot_power_off(),
		.interlock_engaged(), .attn_msg_send(), .pwr_msg_send(up_pmsg), .hotplug_irq(),
		.hotplug_wake(), .irq());
	hpsc_slot_model #(.DELAY(DLY)) u_slot (.aclk, .aresetn, .action_start(start),
		.action_done(done));

	always #5 aclk = ~aclk;
	// Count indicator messages; a hang counts as a mismatch
	always @(posedge aclk)
	begin
		n_attn += amsg;
		n_pwr += pmsg;
		n_up += up_pmsg;
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Address and data offered together; each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		ck("bresp", 32'(e), 32'(bresp));
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		rd_q = rdata;
		ck("rresp", 32'(e), 32'(rresp));
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		rd(a, RESP_OKAY);
		ck("register", e, rd_q);
	endtask
	// Control write, wait out the command, then clear every status flag
	task automatic ctl(input logic [31:0] v);
		wr(HPSC_OFF_CTRL, v, RESP_OKAY);
		wt(DLY + 10);
		wr(HPSC_OFF_STAT, 32'h0000_011F, RESP_OKAY);
		wt(2);
	endtask
	task automatic pulse(input int i);
		@(posedge aclk);
		ev[i] <= 1'h1;
		@(posedge aclk);
		ev[i] <= 1'h0;
		wt(3);
	endtask

	initial
	begin
		wt(12);
		aresetn <= 1'h1;
		rc(HPSC_OFF_CTRL, 32'h0);
		ck("indicators", 32'h0, {28'h0, att, pwr});
		ctl(32'h0000_FFFF);
		rc(HPSC_OFF_CTRL, 32'h0000_1008);
		ck("interlock", 32'h0, {31'h0, ilk});
		wr(HPSC_OFF_CAPS, 32'h0002_005F, RESP_OKAY);
		rc(HPSC_OFF_CTRL, 32'h0000_11C8);
		ck("indicators", 32'h0000_000D, {28'h0, att, pwr});
		for (int i = 1; i < 4; i++)
		begin
			d = {22'h0, i[1:0], i[1:0], 6'h0};
			ctl(d);
			rc(HPSC_OFF_CTRL, d);
			ck("indicators", 32'(i * 5), {28'h0, att, pwr});
		end
		ck("messages", 32'h3_0003, 32'(n_attn * 65536 + n_pwr));
		ck("upstream power", 32'h1, {30'h0, up_pwr});
		ck("upstream messages", 32'h0, 32'(n_up));
		ctl(32'h0000_0CD0);
		rc(HPSC_OFF_CTRL, 32'h0000_04D0);
		ck("power and interlock", 32'h3, {30'h0, poff, ilk});
		wr(HPSC_OFF_CTRL, 32'h0000_00D0, RESP_OKAY);
		rc(HPSC_OFF_STAT, 32'h0000_00C0);
		wt(DLY + 10);
		rc(HPSC_OFF_STAT, 32'h0000_00D0);
		ck("power and interlock", 32'h1, {30'h0, poff, ilk});
		wr(HPSC_OFF_STAT, 32'h0000_0010, RESP_OKAY);
		rc(HPSC_OFF_STAT, 32'h0000_00C0);
		for (int i = 0; i < 5; i++)
		begin
			ctl(32'h0000_00D0 | (32'h1 << en_b[i]));
			pulse(i);
			ck("wake on", 32'h1, {31'h0, wake});
			rc(HPSC_OFF_STAT, 32'h0000_00C0 | (32'h1 << st_b[i]));
			ctl(32'h0000_00D0);
			pulse(i);
			ck("wake off", 32'h0, {31'h0, wake});
		end
		ctl(32'h0000_00F1);
		ck("irq idle", 32'h0, {31'h0, hirq});
		pulse(0);
		ck("irq button", 32'h1, {31'h0, hirq});
		wr(HPSC_OFF_STAT, 32'h0000_011F, RESP_OKAY);
		wr(HPSC_OFF_CTRL, 32'h0000_00F1, RESP_OKAY);
		wt(DLY + 10);
		ck("irq and wake", 32'h2, {30'h0, hirq, wake});
		ctl(32'h0000_00D1);
		pulse(0);
		ck("irq and wake", 32'h1, {30'h0, hirq, wake});
		wr(HPSC_OFF_INTMSK, 32'h0, RESP_OKAY);
		ctl(32'h0000_00D0);
		wr(HPSC_OFF_INTST, 32'h0000_001F, RESP_OKAY);
		wr(HPSC_OFF_CTRL, 32'h0000_00D0, RESP_OKAY);
		wt(DLY + 10);
		ck("irq masked", 32'h0, {31'h0, irq});
		wr(HPSC_OFF_INTMSK, 32'h0000_0002, RESP_OKAY);
		wt(2);
		ck("irq unmasked", 32'h1, {31'h0, irq});
		wr(HPSC_OFF_INTST, 32'h0000_0002, RESP_OKAY);
		wt(2);
		ck("irq cleared", 32'h0, {31'h0, irq});
		wr(12'h100, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(12'h100, RESP_SLVERR);
		ck("unmapped", 32'h0, rd_q);
		end_sim();
	end
endmodule
`default_nettype wire
